/* ufc_pkg.sv */
// package: register map, field layout and reset values of the unknown-frame forwarding control
//
// Function
// - unknown unicast forwarded by its port map only while enable bit 5 set
// - unicast map 00000 drops, 11111 floods all ports, 00001 port 1 only
// - unicast map 00011 sends unknown unicast to ports 1 and 2 together
// - multicast enable bit 5 governs unknown non-IP multicast; IP multicast excluded
// - multicast 5-bit map selects drop, single port, ports 1-2, or all ports
// - unknown VLAN ID frames forwarded by VID map only while bit 5 is one
// - VID 5-bit map selects drop, port 1, ports 1-2, or broadcast to all
// - self-address filter enable bit 6 filters frames addressed to own MAC
// - self filtering happens at egress, comparing against six own-address registers
// - unknown IP multicast has its own enable bit 5 and port map
package ufc_pkg;

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int NPORT = 5;
   localparam int AW    = 8;
   localparam int DW    = 8;
   localparam int NMAC  = 6;

   typedef logic [NPORT-1:0] ufc_map_t;
   typedef logic [AW-1:0]    ufc_addr_t;
   typedef logic [DW-1:0]    ufc_data_t;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam ufc_addr_t UCAST_ADDR = 8'h83;
   localparam ufc_addr_t MCAST_ADDR = 8'h84;
   localparam ufc_addr_t VID_ADDR   = 8'h85;
   localparam ufc_addr_t SELF_ADDR  = 8'h86;
   localparam ufc_addr_t MAC0_ADDR  = 8'h68;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int EN_BIT      = 5;
   localparam int SELF_EN_BIT = 6;
   localparam int DRV_LSB     = 6;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam ufc_data_t UCAST_RST = 8'h00;
   localparam ufc_data_t MCAST_RST = 8'h40;
   localparam ufc_data_t VID_RST   = 8'h00;
   localparam ufc_data_t SELF_RST  = 8'h00;
   localparam ufc_data_t MAC_RST   = 8'h00;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef enum logic [2:0] {
      ufc_cls_ucast  = 3'h0,
      ufc_cls_mcast  = 3'h1,
      ufc_cls_ipmc   = 3'h3,
      ufc_cls_vid    = 3'h2,
      ufc_cls_known  = 3'h6
   } ufc_cls_e;

   typedef struct packed {
      logic      we;
      logic      re;
      ufc_addr_t addr;
      ufc_data_t wdata;
   } ufc_req_s;

   typedef struct packed {
      logic     valid;
      ufc_cls_e cls;
      logic     is_self;
      ufc_map_t known_map;
      ufc_map_t dflt_map;
   } ufc_frm_s;

   typedef struct packed {
      logic     valid;
      logic     use_cfg;
      ufc_map_t dest;
   } ufc_dec_s;

   // map bit k reaches port k+1: identity on the vector
   function automatic ufc_map_t ufc_sel(input logic en, input ufc_map_t map, input ufc_map_t dflt);
      ufc_sel = en ? map : dflt;
   endfunction

endpackage

/* ufc_regfile.sv */
// module: byte-wide register file for the own MAC address
module ufc_regfile
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 srst,
   // access
   input  wire logic                 we,
   input  wire logic [2:0]           widx,
   input  wire ufc_pkg::ufc_data_t   wdata,
   input  wire logic [2:0]           ridx,
   output      ufc_pkg::ufc_data_t   rdata,
   // whole address
   output      logic [8*ufc_pkg::NMAC-1:0] mac
);
   import ufc_pkg::*;

   ufc_data_t mem_q [NMAC];
   ufc_data_t rdata_q;

   // ----------------------------------------
   // storage
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < NMAC; g++) begin : g_byte
         always_ff @(posedge clk) begin
            if (srst)
               mem_q[g] <= MAC_RST;
            else if (we && widx == 3'(g))
               mem_q[g] <= wdata;
         end
         // byte 0 is the most significant octet on the wire
         assign mac[8*(NMAC-1-g) +: 8] = mem_q[g];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (srst)
         rdata_q <= MAC_RST;
      else
         rdata_q <= (ridx < 3'(NMAC)) ? mem_q[ridx] : MAC_RST;
   end

   assign rdata = rdata_q;

endmodule

/* ufc_top.sv */
// module: unknown-frame forwarding control registers and destination decision
module ufc_top
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                srst,
   // management register access
   input  wire ufc_pkg::ufc_req_s   req,
   output      logic                rvalid,
   output      ufc_pkg::ufc_data_t  rdata,
   // frame lookup result in
   input  wire ufc_pkg::ufc_frm_s   frm,
   input  wire logic [47:0]         egress_da,
   input  wire logic                egress_vld,
   // decision out
   output      ufc_pkg::ufc_dec_s   dec,
   output      logic                egress_drop,
   output      logic [1:0]          drive_sel
);
   import ufc_pkg::*;

   // ----------------------------------------
   // register state
   // ----------------------------------------
   logic              uc_en_q;
   logic              mc_en_q;
   logic              vid_en_q;
   logic              ip_en_q;
   logic              self_en_q;
   ufc_map_t          uc_map_q;
   ufc_map_t          mc_map_q;
   ufc_map_t          vid_map_q;
   ufc_map_t          ip_map_q;
   logic [1:0]        drv_q;
   logic              rvalid_q;
   logic              mac_rd_q;
   logic              egress_drop_q;
   ufc_data_t         cfg_rd_q;
   ufc_dec_s          dec_q;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // one match per register, shared by the write strobes and the read select
   wire               sel_uc   = req.addr == UCAST_ADDR;
   wire               sel_mc   = req.addr == MCAST_ADDR;
   wire               sel_vid  = req.addr == VID_ADDR;
   wire               sel_self = req.addr == SELF_ADDR;
   wire               wr_uc    = req.we && sel_uc;
   wire               wr_mc    = req.we && sel_mc;
   wire               wr_vid   = req.we && sel_vid;
   wire               wr_self  = req.we && sel_self;
   wire ufc_addr_t    mac_off  = req.addr - MAC0_ADDR;
   wire               in_mac   = req.addr >= MAC0_ADDR && mac_off < ufc_addr_t'(NMAC);
   wire [2:0]         mac_idx  = mac_off[2:0];
   wire ufc_data_t    mac_rd;
   wire [8*NMAC-1:0]  own_mac;

   ufc_regfile u_mac (
      .clk   (clk),
      .srst  (srst),
      .we    (req.we && in_mac),
      .widx  (mac_idx),
      .wdata (req.wdata),
      .ridx  (mac_idx),
      .rdata (mac_rd),
      .mac   (own_mac)
   );

   // ----------------------------------------
   // config registers
   // ----------------------------------------
   // one short block per register; a write touches only the addressed byte
   always_ff @(posedge clk) begin
      if (srst) begin
         uc_en_q  <= UCAST_RST[EN_BIT];
         uc_map_q <= UCAST_RST[NPORT-1:0];
      end else if (wr_uc) begin
         uc_en_q  <= req.wdata[EN_BIT];
         uc_map_q <= req.wdata[NPORT-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         drv_q    <= MCAST_RST[DRV_LSB +: 2];
         mc_en_q  <= MCAST_RST[EN_BIT];
         mc_map_q <= MCAST_RST[NPORT-1:0];
      end else if (wr_mc) begin
         drv_q    <= req.wdata[DRV_LSB +: 2];
         mc_en_q  <= req.wdata[EN_BIT];
         mc_map_q <= req.wdata[NPORT-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         vid_en_q  <= VID_RST[EN_BIT];
         vid_map_q <= VID_RST[NPORT-1:0];
      end else if (wr_vid) begin
         vid_en_q  <= req.wdata[EN_BIT];
         vid_map_q <= req.wdata[NPORT-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         self_en_q <= SELF_RST[SELF_EN_BIT];
         ip_en_q   <= SELF_RST[EN_BIT];
         ip_map_q  <= SELF_RST[NPORT-1:0];
      end else if (wr_self) begin
         self_en_q <= req.wdata[SELF_EN_BIT];
         ip_en_q   <= req.wdata[EN_BIT];
         ip_map_q  <= req.wdata[NPORT-1:0];
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   // reserved bits read as zero
   wire ufc_data_t cfg_rd =
      sel_uc   ? {2'h0, uc_en_q, uc_map_q} :
      sel_mc   ? {drv_q, mc_en_q, mc_map_q} :
      sel_vid  ? {2'h0, vid_en_q, vid_map_q} :
      sel_self ? {1'h0, self_en_q, ip_en_q, ip_map_q} : 8'h00;

   always_ff @(posedge clk) begin
      if (srst) begin
         rvalid_q <= 1'b0;
         mac_rd_q <= 1'b0;
         cfg_rd_q <= 8'h00;
      end else begin
         rvalid_q <= req.re;
         mac_rd_q <= in_mac;
         cfg_rd_q <= cfg_rd;
      end
   end

   // ----------------------------------------
   // read answer
   // ----------------------------------------
   // both sources come from flip-flops; the mux keeps one cycle of latency
   always_ff @(posedge clk) begin
      if (srst)
         rvalid <= 1'b0;
      else
         rvalid <= rvalid_q;
   end

   always_ff @(posedge clk) begin
      if (srst)
         rdata <= 8'h00;
      else
         rdata <= mac_rd_q ? mac_rd : cfg_rd_q;
   end

   // ----------------------------------------
   // forwarding decision
   // ----------------------------------------
   // ip multicast never looks at the non-ip multicast control
   wire ufc_map_t uc_dest  = ufc_sel(uc_en_q, uc_map_q, frm.dflt_map);
   wire ufc_map_t mc_dest  = ufc_sel(mc_en_q, mc_map_q, frm.dflt_map);
   wire ufc_map_t ip_dest  = ufc_sel(ip_en_q, ip_map_q, frm.dflt_map);
   wire ufc_map_t vid_dest = ufc_sel(vid_en_q, vid_map_q, frm.dflt_map);

   ufc_dec_s dec_d;
   always_comb begin
      dec_d.valid = frm.valid;
      unique case (frm.cls)
         ufc_cls_ucast: begin
            dec_d.dest    = uc_dest;
            dec_d.use_cfg = uc_en_q;
         end
         ufc_cls_mcast: begin
            dec_d.dest    = mc_dest;
            dec_d.use_cfg = mc_en_q;
         end
         ufc_cls_ipmc: begin
            dec_d.dest    = ip_dest;
            dec_d.use_cfg = ip_en_q;
         end
         ufc_cls_vid: begin
            dec_d.dest    = vid_dest;
            dec_d.use_cfg = vid_en_q;
         end
         ufc_cls_known: begin
            dec_d.dest    = frm.known_map;
            dec_d.use_cfg = 1'b0;
         end
         default: begin
            dec_d.dest    = '0;
            dec_d.use_cfg = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // decision register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst)
         dec_q <= '0;
      else
         dec_q <= dec_d;
   end

   // ----------------------------------------
   // egress self-address filter
   // ----------------------------------------
   // compare uses the full 48-bit address; a partial write leaves a mixed value live
   wire self_hit = egress_vld && self_en_q && egress_da == own_mac;

   always_ff @(posedge clk) begin
      if (srst)
         egress_drop_q <= 1'b0;
      else
         egress_drop_q <= self_hit;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // every output is a flip-flop; no logic between register and pin
   assign dec         = dec_q;
   assign egress_drop = egress_drop_q;
   assign drive_sel   = drv_q;

endmodule

/* ufc_checker.sv */
// checker: decision and timing properties of the forwarding control block
module ufc_checker
(
   // clock and reset
   input wire logic               clk,
   input wire logic               srst,
   // register access
   input wire ufc_pkg::ufc_req_s  req,
   input wire logic               rvalid,
   input wire ufc_pkg::ufc_data_t rdata,
   // frame side
   input wire ufc_pkg::ufc_frm_s  frm,
   input wire logic [47:0]        egress_da,
   input wire logic               egress_vld,
   input wire ufc_pkg::ufc_dec_s  dec,
   input wire logic               egress_drop,
   input wire logic [1:0]         drive_sel
);
   import ufc_pkg::*;

   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ------
   // shadow copies, written on the same edge as the block
   // ------
   ufc_data_t   uc_q, mc_q, vd_q, sf_q, cfg;
   ufc_map_t    cmap;
   logic [47:0] mac_q;
   logic [2:0]  midx;
   logic        unk, hit;
   ufc_data_t   rexp;
   assign midx = 3'(req.addr - MAC0_ADDR);
   always_ff @(posedge clk) begin
      if (srst) begin
         uc_q  <= 8'h00;
         mc_q  <= 8'h40;
         vd_q  <= 8'h00;
         sf_q  <= 8'h00;
         mac_q <= 48'h0;
      end else if (req.we) begin
         if (req.addr == UCAST_ADDR) uc_q <= req.wdata;
         if (req.addr == MCAST_ADDR) mc_q <= req.wdata;
         if (req.addr == VID_ADDR) vd_q <= req.wdata;
         if (req.addr == SELF_ADDR) sf_q <= req.wdata;
         if (req.addr >= MAC0_ADDR && req.addr < MAC0_ADDR + 8'h06) mac_q[8*(5-midx) +: 8] <= req.wdata;
      end
   end
   // unmodelled class codes are left out on purpose
   assign cfg = (frm.cls == ufc_cls_ucast) ? uc_q : (frm.cls == ufc_cls_mcast) ? mc_q :
                (frm.cls == ufc_cls_vid) ? vd_q : sf_q;
   assign cmap = cfg[NPORT-1:0];
   assign unk = frm.valid && frm.cls inside {ufc_cls_ucast, ufc_cls_mcast, ufc_cls_vid, ufc_cls_ipmc};
   assign hit = egress_vld && sf_q[SELF_EN_BIT] && egress_da == mac_q;
   // reserved bits read as zero, unmapped addresses read zero
   assign rexp = (req.addr == UCAST_ADDR) ? (uc_q & 8'h3f) :
                 (req.addr == MCAST_ADDR) ? mc_q :
                 (req.addr == VID_ADDR) ? (vd_q & 8'h3f) :
                 (req.addr == SELF_ADDR) ? (sf_q & 8'h7f) :
                 (req.addr >= MAC0_ADDR && req.addr < MAC0_ADDR + 8'h06) ? mac_q[8*(5-midx) +: 8] : 8'h00;
   // ------
   // properties
   // ------
   cfg_map_a: assert property (
      unk && cfg[EN_BIT] |=> dec.use_cfg && dec.dest == $past(cmap))
      else $error("enabled class not sent by its port map");
   dflt_map_a: assert property (unk && !cfg[EN_BIT] |=> !dec.use_cfg && dec.dest == $past(frm.dflt_map))
      else $error("disabled class did not take the default map");
   self_drop_a: assert property (hit |=> egress_drop)
      else $error("own address frame not dropped");
   no_drop_a: assert property (egress_drop |-> $past(hit))
      else $error("drop without own address match");
   rd_lat_a: assert property (req.re |-> ##2 rvalid)
      else $error("read answer missing");
   rd_only_a: assert property (rvalid |-> $past(req.re, 2))
      else $error("read answer without read");
   dec_lat_a: assert property (frm.valid |=> dec.valid)
      else $error("decision missing");
   dec_only_a: assert property (dec.valid |-> $past(frm.valid))
      else $error("decision without frame");
   rd_data_a: assert property (req.re |-> ##2 rdata == $past(rexp, 2))
      else $error("read data differ from register contents");
   drive_sel_a: assert property (drive_sel == mc_q[DRV_LSB +: 2])
      else $error("drive select differs from its field");
   known_map_a: assert property (frm.valid && frm.cls == ufc_cls_known |=> !dec.use_cfg && dec.dest == $past(frm.known_map))
      else $error("known frame not sent by its own map");
endmodule

bind ufc_top ufc_checker u_chk (.clk(clk), .srst(srst), .req(req), .rvalid(rvalid), .rdata(rdata), .frm(frm),
   .egress_da(egress_da), .egress_vld(egress_vld), .dec(dec), .egress_drop(egress_drop), .drive_sel(drive_sel));

/* ufc_top_tb.sv */
// testbench: register access, forwarding decisions and self-address filtering
module ufc_top_tb
   import ufc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   ufc_req_s    req = '0;
   ufc_frm_s    frm = '0;
   logic [47:0] egress_da = 48'h0;
   logic        egress_vld = 1'b0;
   logic        rvalid, egress_drop;
   ufc_data_t   rdata;
   ufc_dec_s    dec;
   logic [1:0]  drive_sel;
   int          err_count = 0;
   int          compares = 0;
   always #2 clk = ~clk;
   ufc_top u_dut (.clk(clk), .srst(srst), .req(req), .rvalid(rvalid), .rdata(rdata), .frm(frm),
      .egress_da(egress_da), .egress_vld(egress_vld), .dec(dec), .egress_drop(egress_drop), .drive_sel(drive_sel));
   // ------
   // helpers
   // ------
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input ufc_addr_t a, input ufc_data_t d);
      req = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
      step();
      req = '0;
   endtask
   // answer comes two edges after the strobe is taken
   task automatic rd(input ufc_addr_t a, input ufc_data_t exp);
      req = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
      step();
      req = '0;
      step();
      chk("rvalid", 8'h01, {7'h0, rvalid});
      chk("rdata", exp, rdata);
   endtask
   // known map differs from the default so a wrong source shows
   task automatic fr(input ufc_cls_e c, input ufc_map_t dflt, input logic use_exp, input ufc_map_t dest);
      frm = '{valid: 1'b1, cls: c, is_self: 1'b0, known_map: dflt ^ 5'h15, dflt_map: dflt};
      step();
      frm = '0;
      chk("dec.valid", 8'h01, {7'h0, dec.valid});
      chk("dec.use_cfg", {7'h0, use_exp}, {7'h0, dec.use_cfg});
      chk("dec.dest", {3'h0, dest}, {3'h0, dec.dest});
   endtask
   task automatic eg(input logic [47:0] da, input logic exp);
      egress_da = da;
      egress_vld = 1'b1;
      step();
      egress_vld = 1'b0;
      chk("egress_drop", {7'h0, exp}, {7'h0, egress_drop});
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_reset();
      rd(UCAST_ADDR, 8'h00);
      rd(MCAST_ADDR, 8'h40);
      rd(VID_ADDR, 8'h00);
      rd(SELF_ADDR, 8'h00);
      rd(MAC0_ADDR, 8'h00);
      chk("drive_sel", 8'h01, {6'h0, drive_sel});
   endtask
   task automatic t_access();
      // an idle edge between two bus calls keeps each strobe change to one per time step
      wr(UCAST_ADDR, 8'hff);
      step();
      rd(UCAST_ADDR, 8'h3f);
      wr(MCAST_ADDR, 8'hff);
      step();
      rd(MCAST_ADDR, 8'hff);
      chk("drive_sel", 8'h03, {6'h0, drive_sel});
      wr(VID_ADDR, 8'hff);
      step();
      rd(VID_ADDR, 8'h3f);
      wr(SELF_ADDR, 8'hff);
      step();
      rd(SELF_ADDR, 8'h7f);
      wr(8'h87, 8'h5a);
      step();
      rd(8'h87, 8'h00);
   endtask
   // each frame follows its write at once, so the new value must be live
   task automatic t_maps();
      ufc_addr_t a[4] = '{UCAST_ADDR, MCAST_ADDR, VID_ADDR, SELF_ADDR};
      ufc_cls_e  c[4] = '{ufc_cls_ucast, ufc_cls_mcast, ufc_cls_vid, ufc_cls_ipmc};
      ufc_map_t  m[5] = '{5'h00, 5'h01, 5'h03, 5'h1f, 5'h14};
      for (int i = 0; i < 4; i++) begin
         for (int j = 0; j < 5; j++) begin
            wr(a[i], 8'h20 | 8'(m[j]));
            fr(c[i], ~m[j], 1'b1, m[j]);
            wr(a[i], 8'(m[j]));
            fr(c[i], 5'h0a ^ m[j], 1'b0, 5'h0a ^ m[j]);
         end
      end
      // known frames ignore every class control and keep their own map
      fr(ufc_cls_known, 5'h0a, 1'b0, 5'h1f);
   endtask
   task automatic t_self();
      logic [47:0] mac = 48'h02a1b2c3d4e5;
      for (int k = 0; k < NMAC; k++) begin
         wr(MAC0_ADDR + 8'(k), mac[47-8*k -: 8]);
         step();
      end
      rd(MAC0_ADDR + 8'h05, 8'he5);
      wr(SELF_ADDR, 8'h40);
      eg(mac, 1'b1);
      step();
      eg(mac ^ 48'h1, 1'b0);
      step();
      eg(mac ^ {1'b1, 47'h0}, 1'b0);
      wr(SELF_ADDR, 8'h00);
      eg(mac, 1'b0);
   endtask
   task automatic summarize();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      step(8);
      srst = 1'b0;
      t_reset();
      t_access();
      t_maps();
      t_self();
      srst = 1'b1;
      step(2);
      srst = 1'b0;
      t_reset();
      summarize();
   end
   initial begin
      #20000;
      err_count++;
      summarize();
   end
endmodule
